// ### core/adc_status_consts.vh
// Register indices, bit positions and widths of the converter status block
`ifndef ADC_STATUS_CONSTS_VH
`define ADC_STATUS_CONSTS_VH

// Register indices; the byte address is four times the index
`define IDX_SEQUENCE_STATUS 6'h06
`define IDX_RESERVED_TEST_ZERO 6'h08
`define IDX_SPECIAL_CHANNEL_TEST 6'h09
`define IDX_UPPER_COMPLETE 6'h0A
`define IDX_LOWER_COMPLETE 6'h0B
`define IDX_STATUS_CONFIG 6'h10

// Address width of the bus slave and the slice holding the index
`define ADDR_W 8
`define ADDR_IDX_HI 7
`define ADDR_IDX_LO 2

// Field positions in sequence_status
`define SEQ_DONE_BIT 7
`define TRIG_OVR_BIT 5
`define RES_OVR_BIT 4
`define CNT_HI 3
`define CNT_LO 0

// Field positions in special_channel_test and status_config
`define SPECIAL_EN_BIT 0
`define CFG_FAST_CLEAR_BIT 0
`define CFG_FIFO_BIT 1
`define CFG_LEVEL_SEL_BIT 2

// Reset values
`define RST_BYTE 8'h00
`define RST_CFG 3'h0
`define RST_CNT 4'h0

// Special channel codes on the low three select bits
`define SPC_HIGH_REF 3'h4
`define SPC_LOW_REF 3'h5
`define SPC_MID_REF 3'h6

// Special selection encoding driven out
`define SEL_NONE 2'h0
`define SEL_HIGH 2'h1
`define SEL_LOW 2'h2
`define SEL_MID 2'h3

`endif

// ### core/complete_flag_cell.v
// One conversion complete flag with its read-armed clear path
`timescale 1ns/1ps
`include "adc_status_consts.vh"

module complete_flag_cell (
	clk,
	reset,
	setFlag,
	startClear,
	statusRead,
	resultRead,
	fastFlagClear,
	flag
);
	input wire clk;
	input wire reset;
	input wire setFlag; // Conversion for this slot finished
	input wire startClear; // Control register 5 written
	input wire statusRead; // Status register holding this flag read
	input wire resultRead; // Result register of this slot read
	input wire fastFlagClear; // Clear on result read alone
	output wire flag;

	reg flag_r;
	reg armed_r; // Status read seen, waiting for the result read
	reg flag_nxt;
	reg armed_nxt;
	wire readClear;

	// Read-based clear, with or without the status read first
	assign readClear = resultRead & (fastFlagClear | armed_r);
	assign flag = flag_r;

	// Next state: start clear beats set, set beats read clears
	always @* begin
		flag_nxt = flag_r;
		armed_nxt = armed_r;
		// R17 read clear paths
		if (readClear) begin
			flag_nxt = 1'b0;
			armed_nxt = 1'b0;
		end
		// Arming only matters once the flag is up
		if (statusRead && flag_r) begin
			armed_nxt = 1'b1;
		end
		// R18 set beats read
		if (setFlag) begin
			flag_nxt = 1'b1;
		end
		// R18 start clear wins
		if (startClear) begin
			flag_nxt = 1'b0;
			armed_nxt = 1'b0;
		end
	end

	// State flops
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_r <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			armed_r <= armed_nxt;
		end
	end
endmodule // complete_flag_cell

// ### core/adc_sequence_status.v
// Status flags, conversion counter and test registers of the converter sequencer
// Functional notes
// R1 - Sequence done flag sets per finished sequence
// R2 - Clear by write one, start, fast read
// R3 - Edge trigger during sequence sets overrun
// R4 - Trigger overrun cleared by write, abort, start
// R5 - Result written over set flag: overrun
// R6 - Result overrun cleared by write, new sequence
// R7 - Four-bit counter readable in status bits 3:0
// R8 - Counter zeroed at sequence ends unless FIFO
// R9 - Counter wraps from maximum to zero
// R10 - Control writes clear counter even in FIFO
// R11 - Software writes never change counter
// R12 - Test zero unpredictable, writable in special
// R13 - Special bit reinterprets channel select bits
// R14 - Codes 4,5,6 pick high, low, midpoint
// R15 - Test one bits 7:6 unpredictable, writable
// R16 - Upper flags set by conversions nine onward
// R17 - Flag clear: start, status+result, fast result
// R18 - Start clear beats set; set beats reads
// R19 - Upper flags readable always, writes ignored
// R20 - Lower flags set by first eight conversions
// R21 - Status bit 6 reads zero
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "adc_status_consts.vh"

module adc_sequence_status #(
	parameter NUM_SLOTS = 16, // Result slots, one per counter value
	parameter CNT_W = 4 // Conversion counter width
) (
	clk,
	reset,
	paddr,
	psel,
	penable,
	pwrite,
	pwdata,
	prdata,
	pready,
	pslverr,
	specialMode,
	startWrite,
	abortWrite,
	triggerEdge,
	triggerStart,
	conversionDone,
	sequenceEnd,
	resultRead,
	resultReadIndex,
	channelSelect,
	completeFlags,
	conversionCounter,
	sequenceActive,
	specialChannelEnable,
	specialSelect,
	specialReserved
);
	input wire clk;
	input wire reset;
	input wire [`ADDR_W-1:0] paddr;
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [31:0] pwdata;
	output wire [31:0] prdata;
	output wire pready;
	output wire pslverr;
	input wire specialMode; // Chip in special (test) mode
	input wire startWrite; // Pulse: control register 5 written
	input wire abortWrite; // Pulse: control registers 0..4 written
	input wire triggerEdge; // Pulse: active external trigger edge
	input wire triggerStart; // Pulse: sequence started by trigger
	input wire conversionDone; // Pulse: result stored at counter slot
	input wire sequenceEnd; // Pulse: last conversion of sequence done
	input wire resultRead; // Pulse: a result register was read
	input wire [CNT_W-1:0] resultReadIndex; // Which result was read
	input wire [3:0] channelSelect; // Select bits of control register 5
	output wire [NUM_SLOTS-1:0] completeFlags;
	output wire [CNT_W-1:0] conversionCounter;
	output wire sequenceActive;
	output wire specialChannelEnable;
	output wire [1:0] specialSelect; // Special source, none when off
	output wire specialReserved; // Special channels on with a reserved code

	// Bus state
	reg [31:0] prdata_r; // Read data captured in the setup cycle
	wire [5:0] regIndex; // Word index of the access
	wire setupRead; // Setup phase of a read
	wire accessDone; // Access phase, completes this edge
	wire wrAccess; // Completing write
	wire rdAccess; // Completing read
	wire mapped; // Address hits a register

	// Sequence state and flags
	reg sequenceDoneFlag_r;
	reg triggerOverrunFlag_r;
	reg resultOverrunFlag_r;
	reg sequenceActive_r;
	reg [CNT_W-1:0] conversionCounter_r;
	reg [CNT_W-1:0] conversionCounter_nxt;
	reg sequenceDoneFlag_nxt;
	reg triggerOverrunFlag_nxt;
	reg resultOverrunFlag_nxt;
	reg sequenceActive_nxt;

	// Software-owned registers
	reg [7:0] testZero_r; // Reserved test zero contents
	reg [7:0] specialTest_r; // Special channel test contents
	reg [2:0] statusConfig_r; // Fast clear, FIFO mode, level select

	// Per-slot strobes into the flag cells
	wire [NUM_SLOTS-1:0] slotSet;
	wire [NUM_SLOTS-1:0] slotResultRead;
	wire [NUM_SLOTS-1:0] slotStatusRead;
	wire lowerRead;
	wire upperRead;
	wire fastFlagClear;
	wire fifoMode;
	wire triggerLevelSelect;
	wire anyStart; // New sequence by write or trigger
	wire currentFlagSet; // Flag of the slot being written already up
	wire [2:0] specialCode; // Reserved mark over the two-bit source code

	// Index equality, used for address decoding
	function hit;
		input [5:0] a;
		input [5:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	// Special channel decode of the select bits
	function [2:0] specialDecode;
		input [3:0] sel;
		begin
			if (sel[3]) begin
				specialDecode = {1'b1, `SEL_NONE};
			end else begin
				case (sel[2:0])
					`SPC_HIGH_REF: specialDecode = {1'b0, `SEL_HIGH};
					`SPC_LOW_REF: specialDecode = {1'b0, `SEL_LOW};
					`SPC_MID_REF: specialDecode = {1'b0, `SEL_MID};
					default: specialDecode = {1'b1, `SEL_NONE};
				endcase
			end
		end
	endfunction

	// Address and phase decode
	assign regIndex = paddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
	assign setupRead = psel & ~penable & ~pwrite;
	assign accessDone = psel & penable;
	assign wrAccess = accessDone & pwrite;
	assign rdAccess = accessDone & ~pwrite;
	assign mapped = hit(regIndex, `IDX_SEQUENCE_STATUS) |
		hit(regIndex, `IDX_RESERVED_TEST_ZERO) |
		hit(regIndex, `IDX_SPECIAL_CHANNEL_TEST) |
		hit(regIndex, `IDX_UPPER_COMPLETE) |
		hit(regIndex, `IDX_LOWER_COMPLETE) |
		hit(regIndex, `IDX_STATUS_CONFIG);

	// Zero wait states; read data is already in flops by the access phase
	assign pready = psel & penable;
	assign pslverr = accessDone & ~mapped;
	assign prdata = prdata_r;

	assign fastFlagClear = statusConfig_r[`CFG_FAST_CLEAR_BIT];
	assign fifoMode = statusConfig_r[`CFG_FIFO_BIT];
	assign triggerLevelSelect = statusConfig_r[`CFG_LEVEL_SEL_BIT];
	assign anyStart = startWrite | triggerStart;

	// Status reads arm the read-then-result clear of their flag half
	// Arming is taken at the access edge, one cycle after the data were captured
	assign lowerRead = rdAccess & hit(regIndex, `IDX_LOWER_COMPLETE);
	assign upperRead = rdAccess & hit(regIndex, `IDX_UPPER_COMPLETE);

	// One flag cell per result slot
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SLOTS; gi = gi + 1) begin : gSlot
			// Counter value that addresses this slot
			localparam [CNT_W-1:0] SLOT = gi;
			// R16 R20 slot set decode
			assign slotSet[gi] = conversionDone & (conversionCounter_r == SLOT);
			// R17 result read routed to its slot
			assign slotResultRead[gi] = resultRead & (resultReadIndex == SLOT);
			// Lower half answers to one status register, upper half to the other
			assign slotStatusRead[gi] = (gi < NUM_SLOTS / 2) ? lowerRead : upperRead;
			complete_flag_cell uCell (
				.clk(clk),
				.reset(reset),
				.setFlag(slotSet[gi]),
				.startClear(startWrite),
				.statusRead(slotStatusRead[gi]),
				.resultRead(slotResultRead[gi]),
				.fastFlagClear(fastFlagClear),
				.flag(completeFlags[gi])
			);
		end
	endgenerate

	// R5 a slot written while its flag is still up
	assign currentFlagSet = |(completeFlags & slotSet);

	// Next state of the sequence flags and counter
	always @* begin
		sequenceDoneFlag_nxt = sequenceDoneFlag_r;
		triggerOverrunFlag_nxt = triggerOverrunFlag_r;
		resultOverrunFlag_nxt = resultOverrunFlag_r;
		sequenceActive_nxt = sequenceActive_r;
		conversionCounter_nxt = conversionCounter_r;

		// Running state: a start opens, an end or abort closes
		if (sequenceEnd || abortWrite) begin
			sequenceActive_nxt = 1'b0;
		end
		if (anyStart) begin
			sequenceActive_nxt = 1'b1;
		end

		// R2 done flag clears
		if (wrAccess && hit(regIndex, `IDX_SEQUENCE_STATUS) && pwdata[`SEQ_DONE_BIT]) begin
			sequenceDoneFlag_nxt = 1'b0;
		end
		if (startWrite || (fastFlagClear && resultRead)) begin
			sequenceDoneFlag_nxt = 1'b0;
		end
		// R1 set per sequence, set wins
		if (sequenceEnd) begin
			sequenceDoneFlag_nxt = 1'b1;
		end

		// R4 trigger overrun clears
		if (wrAccess && hit(regIndex, `IDX_SEQUENCE_STATUS) && pwdata[`TRIG_OVR_BIT]) begin
			triggerOverrunFlag_nxt = 1'b0;
		end
		if (abortWrite || startWrite) begin
			triggerOverrunFlag_nxt = 1'b0;
		end
		// R3 edge during sequence
		if (triggerEdge && !triggerLevelSelect && sequenceActive_r) begin
			triggerOverrunFlag_nxt = 1'b1;
		end

		// R6 result overrun clears
		if (wrAccess && hit(regIndex, `IDX_SEQUENCE_STATUS) && pwdata[`RES_OVR_BIT]) begin
			resultOverrunFlag_nxt = 1'b0;
		end
		if (anyStart) begin
			resultOverrunFlag_nxt = 1'b0;
		end
		// R5 overwrite of set slot
		if (currentFlagSet) begin
			resultOverrunFlag_nxt = 1'b1;
		end

		// R9 free wrap increment
		if (conversionDone) begin
			conversionCounter_nxt = conversionCounter_r + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		// R8 non-FIFO start and end
		if ((triggerStart || sequenceEnd) && !fifoMode) begin
			conversionCounter_nxt = `RST_CNT;
		end
		// R10 control write clears
		if (startWrite || abortWrite) begin
			conversionCounter_nxt = `RST_CNT;
		end
	end

	// Sequence flag and counter flops
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sequenceDoneFlag_r <= 1'b0;
			triggerOverrunFlag_r <= 1'b0;
			resultOverrunFlag_r <= 1'b0;
			sequenceActive_r <= 1'b0;
			conversionCounter_r <= `RST_CNT;
		end else begin
			sequenceDoneFlag_r <= sequenceDoneFlag_nxt;
			triggerOverrunFlag_r <= triggerOverrunFlag_nxt;
			resultOverrunFlag_r <= resultOverrunFlag_nxt;
			sequenceActive_r <= sequenceActive_nxt;
			conversionCounter_r <= conversionCounter_nxt;
		end
	end

	// Software-writable registers; counter bits are never written here
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			testZero_r <= `RST_BYTE;
			specialTest_r <= `RST_BYTE;
			statusConfig_r <= `RST_CFG;
		end else if (wrAccess) begin
			// R12 special mode only
			if (hit(regIndex, `IDX_RESERVED_TEST_ZERO) && specialMode) begin
				testZero_r <= pwdata[7:0];
			end
			// R15 writable any time
			if (hit(regIndex, `IDX_SPECIAL_CHANNEL_TEST)) begin
				specialTest_r <= pwdata[7:0];
			end
			if (hit(regIndex, `IDX_STATUS_CONFIG)) begin
				statusConfig_r <= pwdata[2:0];
			end
		end
	end

	// Read mux, captured in the setup cycle so prdata comes from flops
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata_r <= 32'h00000000;
		end else if (setupRead) begin
			prdata_r <= 32'h00000000;
			case (regIndex)
				// R7 R11 R21 status layout
				`IDX_SEQUENCE_STATUS: prdata_r[7:0] <= {sequenceDoneFlag_r, 1'b0,
					triggerOverrunFlag_r, resultOverrunFlag_r, conversionCounter_r};
				// R12 contents carry no meaning
				`IDX_RESERVED_TEST_ZERO: prdata_r[7:0] <= testZero_r;
				// R15 upper bits unspecified
				`IDX_SPECIAL_CHANNEL_TEST: prdata_r[7:0] <= specialTest_r;
				// R19 read any time
				`IDX_UPPER_COMPLETE: prdata_r[7:0] <= completeFlags[15:8];
				`IDX_LOWER_COMPLETE: prdata_r[7:0] <= completeFlags[7:0];
				`IDX_STATUS_CONFIG: prdata_r[2:0] <= statusConfig_r;
				// Unmapped reads return zero with an error
				default: prdata_r <= 32'h00000000;
			endcase
		end
	end

	// R13 special bit drives decode
	assign specialChannelEnable = specialTest_r[`SPECIAL_EN_BIT];
	// Decode once: bit 2 marks a reserved code, bits 1:0 name the source
	assign specialCode = specialDecode(channelSelect);
	// R14 reference selection
	assign specialSelect = specialChannelEnable ? specialCode[1:0] : `SEL_NONE;
	// R14 reserved codes flagged only while special channels are on
	assign specialReserved = specialChannelEnable & specialCode[2];
	assign conversionCounter = conversionCounter_r;
	assign sequenceActive = sequenceActive_r;
endmodule // adc_sequence_status

// ### testbench/adc_sequence_status_sva.sv
// Checker for the converter status block ports
`timescale 1ns/1ps
`include "adc_status_consts.vh"

module adc_sequence_status_sva #(
	parameter NUM_SLOTS = 16,
	parameter CNT_W = 4
) (
	input wire clk,
	input wire reset,
	input wire startWrite,
	input wire abortWrite,
	input wire triggerEdge,
	input wire triggerStart,
	input wire conversionDone,
	input wire sequenceEnd,
	input wire [3:0] channelSelect,
	input wire [NUM_SLOTS-1:0] completeFlags,
	input wire [CNT_W-1:0] conversionCounter,
	input wire sequenceActive,
	input wire specialChannelEnable,
	input wire [1:0] specialSelect,
	input wire specialReserved
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Any sequence event that may move the counter
	wire cntEvent = startWrite | abortWrite | triggerStart | sequenceEnd | conversionDone;

	a_flag_sets: assert property (conversionDone && !startWrite |=> completeFlags[$past(conversionCounter)])
		else $error("complete flag not set");
	a_start_clears: assert property (startWrite |=> completeFlags == 0 && conversionCounter == 0)
		else $error("start did not clear flags");
	a_abort_clears: assert property (abortWrite |=> conversionCounter == 0)
		else $error("abort did not clear counter");
	a_count_step: assert property (conversionDone && !startWrite && !abortWrite && !triggerStart && !sequenceEnd
		|=> conversionCounter == $past(conversionCounter) + 1'b1)
		else $error("counter step wrong");
	a_count_holds: assert property (!cntEvent |=> $stable(conversionCounter))
		else $error("counter moved without event");
	a_special_off: assert property (!specialChannelEnable |-> specialSelect == `SEL_NONE && !specialReserved)
		else $error("special select while disabled");
	a_special_high: assert property (specialChannelEnable && channelSelect == 4'h4 |-> specialSelect == `SEL_HIGH)
		else $error("high reference not selected");
	a_special_low: assert property (specialChannelEnable && channelSelect == 4'h5 |-> specialSelect == `SEL_LOW)
		else $error("low reference not selected");
	a_special_rsvd: assert property (specialChannelEnable && (channelSelect[3] || !channelSelect[2]
		|| channelSelect[1:0] == 2'h3) |-> specialReserved)
		else $error("reserved code not flagged");

	c_conv: cover property (conversionDone && conversionCounter == 4'hF);
	c_trig: cover property (triggerEdge && sequenceActive);
	c_end: cover property (sequenceEnd);
	c_mid: cover property (specialSelect == `SEL_MID);
endmodule // adc_sequence_status_sva

bind adc_sequence_status adc_sequence_status_sva #(.NUM_SLOTS(NUM_SLOTS), .CNT_W(CNT_W)) chk (.clk(clk),
	.reset(reset), .startWrite(startWrite), .abortWrite(abortWrite), .triggerEdge(triggerEdge),
	.triggerStart(triggerStart), .conversionDone(conversionDone), .sequenceEnd(sequenceEnd),
	.channelSelect(channelSelect), .completeFlags(completeFlags), .conversionCounter(conversionCounter),
	.sequenceActive(sequenceActive), .specialChannelEnable(specialChannelEnable),
	.specialSelect(specialSelect), .specialReserved(specialReserved));

// ### testbench/adc_sequence_status_tb.sv
// Register-level testbench of the converter status block
`timescale 1ns/1ps
`include "adc_status_consts.vh"

module adc_sequence_status_tb;
	// Byte addresses built from the register indices
	localparam logic [7:0] ST = {`IDX_SEQUENCE_STATUS, 2'b00};
	localparam logic [7:0] T0 = {`IDX_RESERVED_TEST_ZERO, 2'b00};
	localparam logic [7:0] T1 = {`IDX_SPECIAL_CHANNEL_TEST, 2'b00};
	localparam logic [7:0] UP = {`IDX_UPPER_COMPLETE, 2'b00};
	localparam logic [7:0] LO = {`IDX_LOWER_COMPLETE, 2'b00};
	localparam logic [7:0] CF = {`IDX_STATUS_CONFIG, 2'b00};
	// Event masks, order as in the ev task
	localparam logic [6:0] START = 7'h40, ABORT = 7'h20, EDGE = 7'h10, TRIG = 7'h08;
	localparam logic [6:0] CONV = 7'h04, SEQEND = 7'h02, RREAD = 7'h01;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, specialMode = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, errSeen, sequenceActive, specialChannelEnable, specialReserved;
	logic startWrite = 0, abortWrite = 0, triggerEdge = 0, triggerStart = 0;
	logic conversionDone = 0, sequenceEnd = 0, resultRead = 0;
	logic [3:0] resultReadIndex = 4'h0, channelSelect = 4'h0, conversionCounter;
	logic [15:0] completeFlags;
	logic [1:0] specialSelect;
	int miscompares = 0, samples_checked = 0;

	adc_sequence_status dut (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.specialMode(specialMode), .startWrite(startWrite), .abortWrite(abortWrite),
		.triggerEdge(triggerEdge), .triggerStart(triggerStart), .conversionDone(conversionDone),
		.sequenceEnd(sequenceEnd), .resultRead(resultRead), .resultReadIndex(resultReadIndex),
		.channelSelect(channelSelect), .completeFlags(completeFlags), .conversionCounter(conversionCounter),
		.sequenceActive(sequenceActive), .specialChannelEnable(specialChannelEnable),
		.specialSelect(specialSelect), .specialReserved(specialReserved));

	// Free-running system clock
	initial begin
		forever #5 clk = ~clk;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		xfer(1'b0, a, 32'h0);
		check(name, rdata, exp);
	endtask

	// One-cycle pulse on the selected event inputs
	task ev(input logic [6:0] m, input logic [3:0] idx);
		@(posedge clk);
		{startWrite, abortWrite, triggerEdge, triggerStart, conversionDone, sequenceEnd, resultRead} <= m;
		resultReadIndex <= idx;
		@(posedge clk);
		{startWrite, abortWrite, triggerEdge, triggerStart, conversionDone, sequenceEnd, resultRead} <= 7'h00;
	endtask

	// Counter looked at once the last edge has settled
	task cchk(input logic [3:0] exp);
		@(negedge clk);
		check("counter", {28'h0, conversionCounter}, {28'h0, exp});
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		miscompares++;
		report_and_stop;
	end

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rchk(ST, 32'h0, "status reset");
		rchk(UP, 32'h0, "upper reset");
		$display("reset test done");
		ev(START, 0);
		@(negedge clk);
		check("active after start", {31'h0, sequenceActive}, 32'h1);
		repeat (10) ev(CONV, 0);
		rchk(ST, 32'h0A, "count ten");
		rchk(UP, 32'h03, "upper flags");
		rchk(LO, 32'hFF, "lower flags");
		xfer(1'b1, UP, 32'hFF);
		rchk(UP, 32'h03, "upper write ignored");
		xfer(1'b1, ST, 32'h4F);
		rchk(ST, 32'h0A, "counter write ignored");
		ev(SEQEND, 0);
		rchk(ST, 32'h80, "sequence done");
		xfer(1'b1, ST, 32'h80);
		rchk(ST, 32'h00, "done write clear");
		$display("sequence test done");
		ev(CONV, 0);
		rchk(ST, 32'h11, "result overrun");
		xfer(1'b1, ST, 32'h10);
		rchk(ST, 32'h01, "overrun write clear");
		ev(CONV, 0);
		ev(TRIG, 0);
		rchk(ST, 32'h00, "trigger start clear");
		xfer(1'b1, CF, 32'h4);
		ev(EDGE, 0);
		rchk(ST, 32'h00, "level mode no overrun");
		xfer(1'b1, CF, 32'h0);
		ev(EDGE, 0);
		rchk(ST, 32'h20, "trigger overrun");
		ev(ABORT, 0);
		@(negedge clk);
		check("idle after abort", {31'h0, sequenceActive}, 32'h0);
		rchk(ST, 32'h00, "abort clears");
		$display("overrun test done");
		rchk(UP, 32'h03, "upper before clear");
		ev(RREAD, 8);
		rchk(UP, 32'h02, "read then result clear");
		xfer(1'b1, CF, 32'h1);
		ev(SEQEND, 0);
		ev(RREAD, 3);
		rchk(ST, 32'h00, "fast done clear");
		ev(RREAD, 0);
		rchk(LO, 32'hF6, "fast flag clear");
		ev(CONV | RREAD, 0);
		rchk(LO, 32'hF7, "set beats read");
		ev(START | CONV, 0);
		rchk(LO, 32'h00, "start beats set");
		cchk(4'h0);
		$display("clear test done");
		xfer(1'b1, CF, 32'h2);
		repeat (17) ev(CONV, 0);
		cchk(4'h1);
		ev(SEQEND, 0);
		cchk(4'h1);
		ev(ABORT, 0);
		cchk(4'h0);
		$display("fifo test done");
		xfer(1'b1, T1, 32'h01);
		rchk(T1, 32'h01, "test one bit");
		check("special enable", {31'h0, specialChannelEnable}, 32'h1);
		for (int c = 4; c < 8; c++) begin
			@(posedge clk);
			channelSelect <= c[3:0];
			@(negedge clk);
			check("special select", {30'h0, specialSelect}, (c == 7) ? 32'h0 : c - 3);
			check("special reserved", {31'h0, specialReserved}, {31'h0, c == 7});
		end
		xfer(1'b1, T0, 32'h5A);
		rchk(T0, 32'h00, "test zero normal");
		specialMode <= 1'b1;
		xfer(1'b1, T0, 32'h5A);
		rchk(T0, 32'h5A, "test zero special");
		rchk(8'h3C, 32'h0, "unmapped read");
		check("unmapped error", {31'h0, errSeen}, 32'h1);
		$display("test register test done");
		report_and_stop;
	end
endmodule // adc_sequence_status_tb
